/* File: rtl/adc_select_sync_sleep_control.sv */
// Converter control: buffered input and reference selection, the locked
// active copy, the conversion sequencer, sleep-time starts and APB registers.
// Assumes an APB master on pclk, an analog core that converts on the active
// selection, and sleep status from CPU logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

`include "adc_ctrl_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module adc_select_sync_sleep_control
    import adc_ctrl_pkg::*;
#(
    parameter int DIV = 4
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 trigger_in,
    input  wire logic                 sleep_quiet_mode,
    input  wire logic                 cpu_halted,
    input  wire logic [`RESULT_W-1:0] core_result,
    output logic      [4:0]           analog_input_select,
    output logic      [1:0]           reference_select,
    output logic                      converter_enable,
    output logic                      conv_begin,
    output logic                      conv_tick,
    output logic                      conv_complete_req
);

    localparam int START_WAIT_MAX = 64;

    logic [7:0]           sel_buf_r;
    logic                 auto_r;
    logic                 free_run_r;
    logic                 enable_r;
    logic [6:0]           active_r;
    logic [6:0]           active_nxt;
    conv_state_t          state_r;
    conv_state_t          state_nxt;
    logic [4:0]           cnt_r;
    logic [4:0]           cnt_nxt;
    logic                 lock_r;
    logic                 lock_nxt;
    logic                 first_r;
    logic                 first_nxt;
    logic                 long_r;
    logic                 long_nxt;
    logic                 pend_r;
    logic                 pend_nxt;
    logic                 done_r;
    logic                 done_nxt;
    logic [`RESULT_W-1:0] result_r;
    logic [`RESULT_W-1:0] result_nxt;
    logic                 begin_nxt;
    logic                 req_nxt;
    logic                 begin_now;
    logic [4:0]           total;
    logic                 trig_s;
    logic                 trig_d_r;
    logic                 halt_d_r;
    logic                 trig_start;
    logic                 sleep_start;
    logic [`RESULT_W-1:0] result_s;
    logic                 tick;
    logic                 wr_sel;
    logic                 wr_ctl;
    logic [31:0]          rdata_nxt;
    logic                 rerr_nxt;

    // Address decode for the error response; the read mux and write strobes compare paddr themselves.
    function automatic logic mapped(input logic [11:0] a);
        return a == `OFF_SELECT || a == `OFF_CONTROL || a == `OFF_RESULT || a == `OFF_STATUS;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin inputs and the converter clock.

    sync_2ff #(.W(1 + `RESULT_W)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({trigger_in, core_result}),
        .dout    ({trig_s, result_s})
    );

    conv_clock_divider #(.DIV(DIV)) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (enable_r),
        .restart (trig_start),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register bus. No access takes a wait state; pready is a flop set from the setup cycle.

    assign wr_sel = psel && penable && pready && pwrite && paddr == `OFF_SELECT;
    assign wr_ctl = psel && penable && pready && pwrite && paddr == `OFF_CONTROL;

    // Read data is built in the setup cycle and presented in the access cycle.
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        rerr_nxt  = psel && !penable && !mapped(paddr);
        case (paddr)
            `OFF_SELECT:  rdata_nxt[7:0] = sel_buf_r;
            `OFF_CONTROL: begin
                rdata_nxt[`CTL_ENABLE]   = enable_r;
                rdata_nxt[`CTL_START]    = pend_r || state_r == ST_CONVERT;
                rdata_nxt[`CTL_AUTO]     = auto_r;
                rdata_nxt[`CTL_DONE]     = done_r;
                rdata_nxt[`CTL_FREE_RUN] = free_run_r;
            end
            `OFF_RESULT:  rdata_nxt[`RESULT_W-1:0] = result_r;
            `OFF_STATUS:  begin
                rdata_nxt[`SEL_REF_HI:`SEL_INPUT_LO] = {active_r[6:5], 1'b0, active_r[4:0]};
                rdata_nxt[`STA_LOCKED] = lock_r;
                rdata_nxt[`STA_BUSY]   = state_r == ST_CONVERT;
            end
            default:      rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Control bits; the selection buffer takes writes at any time.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            sel_buf_r  <= `SEL_RESET;
            enable_r   <= 1'b0;
            auto_r     <= 1'b0;
            free_run_r <= 1'b0;
        end else begin
            prdata  <= rdata_nxt;
            pready  <= psel && !penable;
            pslverr <= rerr_nxt;
            if (wr_sel) begin
                sel_buf_r <= pwdata[7:0];
            end
            if (wr_ctl) begin
                enable_r   <= pwdata[`CTL_ENABLE];
                auto_r     <= pwdata[`CTL_AUTO];
                free_run_r <= pwdata[`CTL_FREE_RUN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Start sources. A trigger edge or a halt only counts while idle, since
    // the core cannot take a second request mid-conversion.

    assign trig_start  = auto_r && enable_r && !free_run_r && trig_s && !trig_d_r
                         && state_r == ST_IDLE && !pend_r;
    assign sleep_start = sleep_quiet_mode && cpu_halted && !halt_d_r && enable_r
                         && !auto_r && state_r == ST_IDLE && !pend_r;
    assign total       = long_r ? `CYC_FIRST : `CYC_NORMAL;

    // Sequencer, completion flag, result and the active selection copy.
    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        lock_nxt   = lock_r;
        first_nxt  = first_r;
        long_nxt   = long_r;
        pend_nxt   = pend_r;
        done_nxt   = done_r;
        result_nxt = result_r;
        active_nxt = active_r;
        begin_nxt  = 1'b0;
        req_nxt    = 1'b0;
        begin_now  = 1'b0;
        if (wr_ctl && pwdata[`CTL_START] && enable_r && state_r == ST_IDLE) begin
            pend_nxt = 1'b1;
        end
        if (trig_start || sleep_start) begin
            pend_nxt = 1'b1;
        end
        if (wr_ctl && pwdata[`CTL_DONE]) begin
            done_nxt = 1'b0;
        end
        case (state_r)
            ST_IDLE: begin
                begin_now = pend_r && tick && enable_r;
            end
            ST_CONVERT: begin
                if (tick && cnt_r == total) begin
                    state_nxt  = ST_IDLE;
                    done_nxt   = 1'b1;
                    req_nxt    = 1'b1;
                    pend_nxt   = 1'b0;
                    result_nxt = result_s;
                    begin_now  = auto_r && free_run_r;
                end else if (tick) begin
                    cnt_nxt = cnt_r + 5'd1;
                    if (cnt_r + 5'd1 == total) begin
                        lock_nxt = 1'b0;
                    end
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (begin_now) begin
            state_nxt = ST_CONVERT;
            cnt_nxt   = 5'd1;
            lock_nxt  = 1'b1;
            long_nxt  = first_r;
            first_nxt = 1'b0;
            pend_nxt  = 1'b0;
            begin_nxt = 1'b1;
        end
        // Tracking stops on the start edge itself, so the copy from the edge before is used.
        if (!lock_r && !begin_now) begin
            active_nxt = {sel_buf_r[`SEL_REF_HI:`SEL_REF_LO],
                          sel_buf_r[`SEL_INPUT_HI:`SEL_INPUT_LO]};
        end
        // Switching off abandons a conversion; the next one is the long kind.
        if (!enable_r) begin
            state_nxt = ST_IDLE;
            lock_nxt  = 1'b0;
            pend_nxt  = 1'b0;
            first_nxt = 1'b1;
            begin_nxt = 1'b0;
        end
    end

    // Reset leaves the sequencer idle and unlocked.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r           <= ST_IDLE;
            cnt_r             <= 5'd0;
            lock_r            <= 1'b0;
            first_r           <= 1'b1;
            long_r            <= 1'b0;
            pend_r            <= 1'b0;
            done_r            <= 1'b0;
            result_r          <= `RESULT_RESET;
            active_r          <= 7'h00;
            conv_begin        <= 1'b0;
            conv_complete_req <= 1'b0;
            trig_d_r          <= 1'b0;
            halt_d_r          <= 1'b0;
        end else begin
            state_r           <= state_nxt;
            cnt_r             <= cnt_nxt;
            lock_r            <= lock_nxt;
            first_r           <= first_nxt;
            long_r            <= long_nxt;
            pend_r            <= pend_nxt;
            done_r            <= done_nxt;
            result_r          <= result_nxt;
            active_r          <= active_nxt;
            conv_begin        <= begin_nxt;
            conv_complete_req <= req_nxt;
            trig_d_r          <= trig_s;
            halt_d_r          <= cpu_halted;
        end
    end

    assign analog_input_select = active_r[4:0];
    assign reference_select    = active_r[6:5];
    assign converter_enable    = enable_r;
    assign conv_tick           = tick;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_sleep_req;
        sleep_start;
    endsequence

    sequence s_begins;
        ##[1:START_WAIT_MAX] conv_begin;
    endsequence

    a_freeze_active: assert property (@(posedge pclk) disable iff (!presetn)
        lock_r && $past(lock_r) |-> active_r == $past(active_r))
        else $error("Active selection changed while locked.");
    a_track_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !lock_r && !begin_now && enable_r |=> active_r == {$past(sel_buf_r[7:6]),
                                                           $past(sel_buf_r[4:0])})
        else $error("Active selection did not follow the buffer while idle.");
    a_begin_on_tick: assert property (@(posedge pclk) disable iff (!presetn)
        conv_begin |-> $past(tick) && lock_r && state_r == ST_CONVERT)
        else $error("Conversion began off a converter clock edge.");
    a_unlock_last: assert property (@(posedge pclk) disable iff (!presetn)
        conv_complete_req && DIV > 1 |-> !$past(lock_r, 2))
        else $error("Selection still locked in the last converter cycle.");
    a_free_run_keep: assert property (@(posedge pclk) disable iff (!presetn)
        conv_complete_req && auto_r && free_run_r && enable_r
        |-> conv_begin && active_r == $past(active_r))
        else $error("Free running restart did not keep the previous selection.");
    a_done_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        conv_complete_req |-> done_r && result_r == $past(result_s))
        else $error("Completion did not set the flag and load the result.");

    a_sleep_start: assert property (@(posedge pclk) disable iff (!presetn)
        s_sleep_req ##1 enable_r[*1] |-> s_begins)
        else $error("Sleep start did not begin a conversion in time.");

    a_start_bit_busy: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_CONVERT |-> !pend_r ##1 (state_r == ST_CONVERT || !pend_r || !enable_r))
        else $error("Start request pending while converting.");

    a_reset_idle: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> state_r == ST_IDLE && !lock_r)
        else $error("Converter not idle after reset.");

endmodule

`default_nettype wire

/* File: rtl/adc_ctrl_regs.svh */
// Register offsets, field positions, reset values and cycle counts of the
// converter control block. Included by its bare name; definitions only.
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// Byte offsets on the register bus.
`define OFF_SELECT       12'h000
`define OFF_CONTROL      12'h004
`define OFF_RESULT       12'h008
`define OFF_STATUS       12'h00C

// Selection register fields.
`define SEL_REF_HI       7
`define SEL_REF_LO       6
`define SEL_ADJUST       5
`define SEL_INPUT_HI     4
`define SEL_INPUT_LO     0
`define SEL_RESET        8'h00

// Control register fields.
`define CTL_ENABLE       7
`define CTL_START        6
`define CTL_AUTO         5
`define CTL_DONE         4
`define CTL_FREE_RUN     0

// Status register fields.
`define STA_LOCKED       8
`define STA_BUSY         9

// Result width and converter cycles per conversion.
`define RESULT_W         10
`define RESULT_RESET     10'h000
`define CYC_FIRST        5'd25
`define CYC_NORMAL       5'd13

`endif

/* File: rtl/adc_ctrl_pkg.sv */
// Types shared by the converter control block.
// Assumes nothing of its surroundings.
package adc_ctrl_pkg;

    // Conversion sequencer states.
    typedef enum logic {
        ST_IDLE,
        ST_CONVERT
    } conv_state_t;

endpackage

/* File: rtl/sync_2ff.sv */
// Two-flop synchroniser for a bus of levels from outside the pclk domain.
// Assumes each bit is a level that stays put for several pclk cycles.
`timescale 1ns/1ns
`default_nettype none

module sync_2ff #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_r;

    // The first stage is read by the second stage and nothing else.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule

`default_nettype wire

/* File: rtl/conv_clock_divider.sv */
// Prescaled converter clock, given as a one-cycle tick per converter period.
// Assumes run is the converter enable; restart comes from a trigger edge.
`timescale 1ns/1ns
`default_nettype none

module conv_clock_divider #(
    parameter int DIV = 4
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run,
    input  wire logic restart,
    output logic      tick
);

    localparam int CW = $clog2(DIV);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          tick_nxt;

    // Held in reset while the converter is off, so it starts from a known phase.
    always_comb begin
        cnt_nxt  = cnt_r + 1'b1;
        tick_nxt = 1'b0;
        if (!run || restart) begin
            cnt_nxt = '0;
        end else if (cnt_r == CW'(DIV - 1)) begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick  <= tick_nxt;
        end
    end

endmodule

`default_nettype wire

/* File: sim/adc_select_sync_sleep_control_tb_top.sv */
// Self-checking bench for the converter control block.
// Assumes the design sources and adc_ctrl_regs.svh are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_regs.svh"

module adc_select_sync_sleep_control_tb_top;
    localparam int DIV = 4;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        trigger_in;
    logic        sleep_quiet_mode;
    logic        cpu_halted;
    logic [9:0]  core_result;
    logic [4:0]  analog_input_select;
    logic [1:0]  reference_select;
    logic        converter_enable;
    logic        conv_begin;
    logic        conv_tick;
    logic        conv_complete_req;
    int          n_mismatch;
    int          n_compared;
    int          n_begin;
    int          n_conv;
    int          n_ticks;
    int          exp_cyc;
    int          cycles;
    int          i;
    int          nb;
    logic        in_conv;
    logic        first_pend;
    logic        free_mode;
    logic        tick_prev;
    logic [6:0]  exp_act;
    logic [6:0]  locked_q[$];
    logic [31:0] q;
    logic        err;
    logic [31:0] d1;
    logic [31:0] d2;

    adc_select_sync_sleep_control #(.DIV(DIV)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trigger_in(trigger_in),
        .sleep_quiet_mode(sleep_quiet_mode), .cpu_halted(cpu_halted),
        .core_result(core_result), .analog_input_select(analog_input_select),
        .reference_select(reference_select), .converter_enable(converter_enable),
        .conv_begin(conv_begin), .conv_tick(conv_tick),
        .conv_complete_req(conv_complete_req)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Free-running clock at 50 ns.
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task give_verdict;
        $display("Counts: compared=%0d mismatched=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One APB transfer; an idle cycle follows so psel is never driven twice in a step.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int w;
        w = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No local limit: a lost answer is left to the hang guard.
        do begin
            @(posedge pclk);
            w++;
        end while (pready !== 1'b1);
        chk(w, 1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (wr && a == `OFF_SELECT) exp_act = {d[7:6], d[4:0]};
        if (wr && a == `OFF_CONTROL && !d[`CTL_ENABLE]) first_pend = 1'b1;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
        chk(err, exp_err);
    endtask

    // Waits, bounded, until the begin (which=0) or completion (which=1) count reaches k.
    task wait_cnt(input logic which, input int k);
        int w;
        w = 0;
        while ((which ? n_conv : n_begin) < k && w < 2000) begin
            @(posedge pclk);
            w++;
        end
        chk(w < 2000, 1'b1);
    endtask

    task quiet;
        int b0;
        b0 = n_begin;
        repeat (200) @(posedge pclk);
        chk(n_begin, b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Reference model of one conversion: tick count, frozen and released selection.
    // The lock check stops one tick early because the selection is released for the last converter cycle.
    always @(posedge pclk) begin
        if (converter_enable !== 1'b1) in_conv = 1'b0;
        if (in_conv && n_ticks < exp_cyc - 1)
            chk({reference_select, analog_input_select}, locked_q[$]);
        if (in_conv && conv_tick === 1'b1) n_ticks++;
        if (conv_complete_req === 1'b1) begin
            chk(n_ticks, exp_cyc);
            chk({reference_select, analog_input_select}, exp_act);
            in_conv = 1'b0;
            n_conv++;
        end
        if (conv_begin === 1'b1) begin
            if (!free_mode) chk(tick_prev, 1'b1);
            chk({reference_select, analog_input_select}, exp_act);
            locked_q.push_back({reference_select, analog_input_select});
            exp_cyc = first_pend ? 25 : 13;
            first_pend = 1'b0;
            n_ticks = 0;
            in_conv = 1'b1;
            n_begin++;
        end
        tick_prev = conv_tick;
    end

    // Hang guard: the whole run needs about a thousand cycles.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            give_verdict;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        trigger_in = 1'b0;
        sleep_quiet_mode = 1'b0;
        cpu_halted = 1'b0;
        core_result = 10'h000;
        {n_mismatch, n_compared, n_begin, n_conv, n_ticks, cycles} = '0;
        exp_cyc = 13;
        in_conv = 1'b0;
        first_pend = 1'b1;
        free_mode = 1'b0;
        tick_prev = 1'b0;
        exp_act = 7'h00;
        void'($urandom(34));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, unmapped place and a start that is refused while disabled.
        chk({reference_select, analog_input_select, converter_enable}, 0);
        rd(`OFF_SELECT, 32'h0000_0000, 1'b0);
        rd(`OFF_CONTROL, 32'h0000_0000, 1'b0);
        rd(`OFF_STATUS, 32'h0000_0000, 1'b0);
        rd(`OFF_RESULT, 32'h0000_0000, 1'b0);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        chk(err, 1'b1);
        rd(12'h010, 32'h0000_0000, 1'b1);
        apb(1'b1, `OFF_CONTROL, 32'h0000_0040);
        quiet();
        $display("test reset done");
        // Idle: the active copy follows every buffer write.
        for (i = 0; i < 4; i++) begin
            d1 = $urandom & 32'h0000_00FF;
            apb(1'b1, `OFF_SELECT, d1);
            rd(`OFF_SELECT, d1, 1'b0);
            chk({reference_select, analog_input_select}, exp_act);
            rd(`OFF_STATUS, {d1[7:6], 1'b0, d1[4:0]}, 1'b0);
        end
        $display("test idle tracking done");
        // Single conversion with a selection written while it runs.
        core_result <= 10'($urandom);
        d1 = $urandom & 32'h0000_00DF;
        d2 = d1 ^ 32'h0000_00DF;
        apb(1'b1, `OFF_SELECT, d1);
        apb(1'b1, `OFF_CONTROL, 32'h0000_0080);
        chk(converter_enable, 1'b1);
        // The begin may fall inside the read below, so its count is taken first.
        nb = n_begin;
        apb(1'b1, `OFF_CONTROL, 32'h0000_00C0);
        rd(`OFF_CONTROL, 32'h0000_00C0, 1'b0);
        wait_cnt(1'b0, nb + 1);
        repeat (DIV) @(posedge pclk);
        apb(1'b1, `OFF_SELECT, d2);
        rd(`OFF_STATUS, {22'h0, 2'b11, d1[7:6], 1'b0, d1[4:0]}, 1'b0);
        wait_cnt(1'b1, n_conv + 1);
        rd(`OFF_CONTROL, 32'h0000_0090, 1'b0);
        // Results are compared only as codes handed through from the core, never
        // taken as measurements, so no unsettled first result is ever trusted.
        rd(`OFF_RESULT, {22'h0, core_result}, 1'b0);
        chk(locked_q[$], {d1[7:6], d1[4:0]});
        apb(1'b1, `OFF_CONTROL, 32'h0000_0090);
        rd(`OFF_CONTROL, 32'h0000_0080, 1'b0);
        apb(1'b1, `OFF_CONTROL, 32'h0000_00C0);
        wait_cnt(1'b1, n_conv + 1);
        chk(locked_q[$], {d2[7:6], d2[4:0]});
        $display("test single conversion done");
        // Free running: the first restart keeps d1; the second takes d2, written during the conversion before it.
        apb(1'b1, `OFF_CONTROL, 32'h0000_0000);
        d1 = $urandom & 32'h0000_00DF;
        d2 = d1 ^ 32'h0000_001F;
        apb(1'b1, `OFF_SELECT, d1);
        i = locked_q.size();
        free_mode = 1'b1;
        // A start is refused while the converter is off, so enable it first.
        apb(1'b1, `OFF_CONTROL, 32'h0000_00A1);
        apb(1'b1, `OFF_CONTROL, 32'h0000_00E1);
        wait_cnt(1'b1, n_conv + 1);
        apb(1'b1, `OFF_SELECT, d2);
        wait_cnt(1'b0, n_begin + 2);
        chk(locked_q[i + 1], {d1[7:6], d1[4:0]});
        chk(locked_q[i + 2], {d2[7:6], d2[4:0]});
        apb(1'b1, `OFF_CONTROL, 32'h0000_0000);
        free_mode = 1'b0;
        $display("test free running done");
        // External trigger edge starts a conversion.
        apb(1'b1, `OFF_CONTROL, 32'h0000_00A0);
        trigger_in <= 1'b1;
        wait_cnt(1'b0, n_begin + 1);
        wait_cnt(1'b1, n_conv + 1);
        trigger_in <= 1'b0;
        apb(1'b1, `OFF_CONTROL, 32'h0000_0000);
        $display("test auto trigger done");
        // Sleep: other modes start nothing; quiet sleep starts and requests wake-up.
        apb(1'b1, `OFF_CONTROL, 32'h0000_0080);
        cpu_halted <= 1'b1;
        quiet();
        chk(converter_enable, 1'b1);
        cpu_halted <= 1'b0;
        // After a sleep with the converter left on, toggle it off and on again.
        apb(1'b1, `OFF_CONTROL, 32'h0000_0000);
        apb(1'b1, `OFF_CONTROL, 32'h0000_0080);
        @(posedge pclk);
        sleep_quiet_mode <= 1'b1;
        cpu_halted <= 1'b1;
        wait_cnt(1'b0, n_begin + 1);
        cpu_halted <= 1'b0;
        wait_cnt(1'b1, n_conv + 1);
        sleep_quiet_mode <= 1'b0;
        $display("test sleep done");
        give_verdict;
    end
endmodule
`default_nettype wire
